// File: verilog/dscg_pkg.sv
// Constants and carrier types of the deep-sleep clock gating block
package dscg_pkg;

	// Register offsets (byte addresses)
	localparam logic [11:0] RUN_CFG_OFS    = 12'h100;
	localparam logic [11:0] RUN_GATE_OFS   = 12'h104;
	localparam logic [11:0] SLEEP_GATE_OFS = 12'h118;
	localparam logic [11:0] DEEP_GATE_OFS  = 12'h128;

	// Field positions in the gate registers
	localparam int unsigned PHY_BIT   = 30;
	localparam int unsigned MAC_BIT   = 28;
	localparam int unsigned PORT_LSB  = 0;
	localparam int unsigned NUM_PORTS = 8;
	localparam int unsigned NUM_UNITS = 10;

	// Field positions in the run clock configuration register
	localparam int unsigned ACG_BIT      = 0;
	localparam int unsigned SLEEP_ST_BIT = 1;
	localparam int unsigned DEEP_ST_BIT  = 2;

	// Writable bits of a gate register
	localparam logic [31:0] GATE_MASK = 32'h5000_00ff;

	// Reset values
	localparam logic [31:0] GATE_RST = 32'h0000_0000;
	localparam logic        ACG_RST  = 1'h0;

	// Avalon-MM request from the master
	typedef struct packed {
		logic        read;
		logic        write;
		logic [11:0] address;
		logic [3:0]  byteenable;
		logic [31:0] writedata;
	} dscg_bus_req_t;

	// Whole state of the block
	typedef struct packed {
		logic [31:0]          run;
		logic [31:0]          slp;
		logic [31:0]          deep;
		logic                 auto_clock_gate_select;
		logic                 wreq;
		logic [31:0]          rdata;
		logic [NUM_UNITS-1:0] clk_en;
		logic [NUM_UNITS-1:0] fault;
	} dscg_state_t;

endpackage

// File: verilog/dscg_top.sv
// Peripheral clock gating control with run, sleep and deep-sleep gate registers
//
// Function
// - A unit gets its clock enable only while its applied gate bit is set.
// - An access strobe to a unit whose clock is gated off raises that unit's fault.
// - All gate bits reset to zero so every unit starts unclocked.
// - Three gate registers exist, for run, sleep and deep sleep at 0x128.
// - Sleep and deep-sleep gates apply only while the auto gating select bit is set.
// - Bit 30 of the deep-sleep gate register is the writable PHY gate.
// - Bit 28 of the deep-sleep gate register is the writable MAC gate.
// - Bits 7 to 0 are the writable gates for ports H down to A.
// - Positions without a unit behave as reserved read-only bits.
// - The sleep gate register at 0x118 has the same layout as the deep-sleep one.
//
// Added by the designer: the Avalon-MM interface to the registers.
`timescale 1ns/1ps

module dscg_top
	import dscg_pkg::*;
(
	input  wire logic                 core_clk,        // System clock, 125 MHz
	input  wire logic                 rstn,            // Asynchronous reset, active low
	input  wire dscg_bus_req_t        avs_req,         // Avalon-MM request group
	output logic [31:0]               avs_readdata,    // Avalon-MM read data
	output logic                      avs_waitrequest, // Avalon-MM wait request
	input  wire logic                 sleep_now,       // Core is in sleep mode
	input  wire logic                 deep_sleep_now,  // Core is in deep-sleep mode
	input  wire logic [NUM_UNITS-1:0] unit_sel,        // Access strobe per unit
	output logic [NUM_UNITS-1:0]      unit_clk_en,     // Clock enable per unit
	output logic [NUM_UNITS-1:0]      unit_fault       // Bus fault pulse per unit
);

	////////////////////////////////////////////////////////////////////////////////
	// Helpers

	// Gate vector of one register: PHY, MAC, ports H..A
	function automatic logic [NUM_UNITS-1:0] units_of(input logic [31:0] r);
		units_of = {r[PHY_BIT], r[MAC_BIT], r[PORT_LSB +: NUM_PORTS]};
	endfunction

	dscg_state_t st_ff;
	dscg_state_t nxt_st;
	logic [31:0] be_mask;
	logic [31:0] wr_mask;
	logic [31:0] rd_val;
	logic        req_on;
	logic        wr_take;

	////////////////////////////////////////////////////////////////////////////////
	// Byte lanes

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_lane
			assign be_mask[gi*8 +: 8] = {8{avs_req.byteenable[gi]}};
		end
	endgenerate

	assign wr_mask = be_mask & GATE_MASK;
	assign req_on  = avs_req.read | avs_req.write;
	assign wr_take = avs_req.write & ~st_ff.wreq;

	////////////////////////////////////////////////////////////////////////////////
	// Read multiplexer

	always_comb
	begin
		rd_val = 32'h0000_0000;
		case (avs_req.address)
			RUN_CFG_OFS:
			begin
				rd_val[ACG_BIT]      = st_ff.auto_clock_gate_select;
				rd_val[SLEEP_ST_BIT] = sleep_now;
				rd_val[DEEP_ST_BIT]  = deep_sleep_now;
			end
			RUN_GATE_OFS:   rd_val = st_ff.run & GATE_MASK;
			SLEEP_GATE_OFS: rd_val = st_ff.slp & GATE_MASK;
			DEEP_GATE_OFS:  rd_val = st_ff.deep & GATE_MASK;
			default:        rd_val = 32'h0000_0000;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb
	begin
		nxt_st = st_ff;

		// One wait cycle, then a single cycle of completion
		nxt_st.wreq = 1'b1;
		if (req_on && st_ff.wreq)
		begin
			nxt_st.wreq = 1'b0;
			if (avs_req.read)
			begin
				nxt_st.rdata = rd_val;
			end
		end

		// Writes take effect at the completing edge
		if (wr_take)
		begin
			case (avs_req.address)
				RUN_CFG_OFS:
				begin
					if (avs_req.byteenable[0])
					begin
						nxt_st.auto_clock_gate_select = avs_req.writedata[ACG_BIT];
					end
				end
				RUN_GATE_OFS:
				begin
					nxt_st.run = (st_ff.run & ~wr_mask)
						| (avs_req.writedata & wr_mask);
				end
				SLEEP_GATE_OFS:
				begin
					nxt_st.slp = (st_ff.slp & ~wr_mask)
						| (avs_req.writedata & wr_mask);
				end
				DEEP_GATE_OFS:
				begin
					nxt_st.deep = (st_ff.deep & ~wr_mask)
						| (avs_req.writedata & wr_mask);
				end
				default:
				begin
					nxt_st.auto_clock_gate_select = st_ff.auto_clock_gate_select;
				end
			endcase
		end

		// Applied gates follow the current power mode while auto gating is selected, else the run gates apply
		if (st_ff.auto_clock_gate_select && deep_sleep_now)
		begin
			nxt_st.clk_en = units_of(st_ff.deep);
		end
		else if (st_ff.auto_clock_gate_select && sleep_now)
		begin
			nxt_st.clk_en = units_of(st_ff.slp);
		end
		else
		begin
			nxt_st.clk_en = units_of(st_ff.run);
		end

		// Access to an unclocked unit faults
		nxt_st.fault = unit_sel & ~st_ff.clk_en;
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			st_ff.run    <= GATE_RST;
			st_ff.slp    <= GATE_RST;
			st_ff.deep   <= GATE_RST;
			st_ff.auto_clock_gate_select    <= ACG_RST;
			st_ff.wreq   <= 1'b1;
			st_ff.rdata  <= 32'h0000_0000;
			st_ff.clk_en <= '0;
			st_ff.fault  <= '0;
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end

	assign avs_readdata    = st_ff.rdata;
	assign avs_waitrequest = st_ff.wreq;
	assign unit_clk_en     = st_ff.clk_en;
	assign unit_fault      = st_ff.fault;

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge core_clk);
	endclocking

	default disable iff (!rstn);

	a_bus_one_wait: assert property (
		(req_on && avs_waitrequest) |=> !avs_waitrequest ##1 avs_waitrequest
	) else $error("waitrequest did not drop for exactly one cycle");

	a_reserved_zero: assert property (
		((st_ff.deep | st_ff.slp | st_ff.run) & ~GATE_MASK) == 32'h0000_0000
	) else $error("reserved gate bit became set");

	a_deep_follow: assert property (
		(st_ff.auto_clock_gate_select && deep_sleep_now)
			|=> unit_clk_en == units_of($past(st_ff.deep))
	) else $error("deep-sleep gates not applied");

	a_sleep_follow: assert property (
		(st_ff.auto_clock_gate_select && sleep_now && !deep_sleep_now)
			|=> unit_clk_en == units_of($past(st_ff.slp))
	) else $error("sleep gates not applied");

	a_run_noacg: assert property (
		!st_ff.auto_clock_gate_select |=> unit_clk_en == units_of($past(st_ff.run))
	) else $error("run gates not applied without auto gating");

	a_fault_gated: assert property (
		##1 unit_fault == ($past(unit_sel) & ~$past(unit_clk_en))
	) else $error("fault does not match gated access");

	a_wr_eth: assert property (
		(wr_take && avs_req.address == DEEP_GATE_OFS && avs_req.byteenable[3])
			|=> st_ff.deep[PHY_BIT] == $past(avs_req.writedata[PHY_BIT])
			&& st_ff.deep[MAC_BIT] == $past(avs_req.writedata[MAC_BIT])
	) else $error("deep-sleep PHY or MAC gate not written");

	a_wr_port: assert property (
		(wr_take && avs_req.address == DEEP_GATE_OFS && avs_req.byteenable[0])
			|=> st_ff.deep[7:0] == $past(avs_req.writedata[7:0])
	) else $error("deep-sleep port gates not written");

	a_rd_deep: assert property (
		(avs_req.read && avs_waitrequest && avs_req.address == DEEP_GATE_OFS)
			|=> avs_readdata == ($past(st_ff.deep) & GATE_MASK)
	) else $error("deep-sleep register read wrong");

	a_rst_state: assert property (
		$rose(rstn)
			|-> st_ff.run == GATE_RST && st_ff.slp == GATE_RST && st_ff.deep == GATE_RST
			&& unit_clk_en == '0 && !st_ff.auto_clock_gate_select
	) else $error("state not cleared by reset");

	a_en_needs_gate: assert property (
		##1 (unit_clk_en & ~(units_of($past(st_ff.run)) | units_of($past(st_ff.slp))
			| units_of($past(st_ff.deep)))) == '0
	) else $error("clock enabled without a set gate bit");

	a_acg_run: assert property (
		(st_ff.auto_clock_gate_select && !sleep_now && !deep_sleep_now)
			|=> unit_clk_en == units_of($past(st_ff.run))
	) else $error("run gates not applied in run mode");

	a_fault_clocked: assert property (
		##1 (unit_fault & $past(unit_clk_en)) == '0
	) else $error("fault raised on a clocked unit");

	a_wr_slp_eth: assert property (
		(wr_take && avs_req.address == SLEEP_GATE_OFS && avs_req.byteenable[3])
			|=> st_ff.slp[PHY_BIT] == $past(avs_req.writedata[PHY_BIT])
			&& st_ff.slp[MAC_BIT] == $past(avs_req.writedata[MAC_BIT])
	) else $error("sleep PHY or MAC gate not written");

	a_wr_slp_port: assert property (
		(wr_take && avs_req.address == SLEEP_GATE_OFS && avs_req.byteenable[0])
			|=> st_ff.slp[7:0] == $past(avs_req.writedata[7:0])
	) else $error("sleep port gates not written");

	a_eth_lane_keep: assert property (
		(wr_take && avs_req.address == DEEP_GATE_OFS && !avs_req.byteenable[3])
			|=> st_ff.deep[PHY_BIT] == $past(st_ff.deep[PHY_BIT])
			&& st_ff.deep[MAC_BIT] == $past(st_ff.deep[MAC_BIT])
	) else $error("deep-sleep PHY or MAC gate changed without its lane");

	a_deep_kept: assert property (
		(wr_take && avs_req.address != DEEP_GATE_OFS)
			|=> st_ff.deep == $past(st_ff.deep)
	) else $error("deep-sleep gates changed by another write");

	a_slp_kept: assert property (
		(wr_take && avs_req.address != SLEEP_GATE_OFS)
			|=> st_ff.slp == $past(st_ff.slp)
	) else $error("sleep gates changed by another write");

	a_rd_sleep: assert property (
		(avs_req.read && avs_waitrequest && avs_req.address == SLEEP_GATE_OFS)
			|=> avs_readdata == ($past(st_ff.slp) & GATE_MASK)
	) else $error("sleep register read wrong");

	a_rd_run: assert property (
		(avs_req.read && avs_waitrequest && avs_req.address == RUN_GATE_OFS)
			|=> avs_readdata == ($past(st_ff.run) & GATE_MASK)
	) else $error("run gate register read wrong");

	a_rd_unmapped: assert property (
		(avs_req.read && avs_waitrequest && avs_req.address != RUN_CFG_OFS
			&& avs_req.address != RUN_GATE_OFS && avs_req.address != SLEEP_GATE_OFS
			&& avs_req.address != DEEP_GATE_OFS)
			|=> avs_readdata == 32'h0000_0000
	) else $error("unmapped read not zero");

	a_rd_cfg: assert property (
		(avs_req.read && avs_waitrequest && avs_req.address == RUN_CFG_OFS)
			|=> avs_readdata[ACG_BIT] == $past(st_ff.auto_clock_gate_select) && avs_readdata[31:3] == 29'h0
	) else $error("clock configuration read wrong");

	a_acg_write: assert property (
		(wr_take && avs_req.address == RUN_CFG_OFS && avs_req.byteenable[0])
			|=> st_ff.auto_clock_gate_select == $past(avs_req.writedata[ACG_BIT])
	) else $error("auto gating select not written");

	a_bus_idle: assert property (
		(!req_on && avs_waitrequest) |=> avs_waitrequest
	) else $error("waitrequest dropped with no request");

	a_rd_hold: assert property (
		!(avs_req.read && avs_waitrequest) |=> $stable(avs_readdata)
	) else $error("read data changed without a read");

endmodule

// File: sim/dscg_top_test.sv
// Self-checking bench of the deep-sleep clock gating block
`timescale 1ns/1ps

module dscg_top_test
	import dscg_pkg::*;
;
	logic                 core_clk;
	logic                 rstn;
	dscg_bus_req_t        req;
	logic [31:0]          rdata;
	logic                 waitreq;
	logic                 sleep_now;
	logic                 deep_sleep_now;
	logic [NUM_UNITS-1:0] unit_sel;
	logic [NUM_UNITS-1:0] clk_en;
	logic [NUM_UNITS-1:0] fault;
	logic [31:0]          q;
	int                   miscompares;
	int                   n_compared;
	logic [11:0]          gofs [3] = '{12'h104, 12'h118, 12'h128};
	logic [31:0]          gpat [3] = '{32'h1000_0001, 32'h4000_0002, 32'h5000_0084};
	// Mode cases as {deep, sleep, auto select} and the gate register each selects
	logic [2:0]           mtab [5] = '{3'h4, 3'h1, 3'h3, 3'h7, 3'h5};
	int                   midx [5] = '{0, 0, 1, 2, 2};

	dscg_top DUT (
		.core_clk        (core_clk),
		.rstn            (rstn),
		.avs_req         (req),
		.avs_readdata    (rdata),
		.avs_waitrequest (waitreq),
		.sleep_now       (sleep_now),
		.deep_sleep_now  (deep_sleep_now),
		.unit_sel        (unit_sel),
		.unit_clk_en     (clk_en),
		.unit_fault      (fault)
	);

	always #4 core_clk = ~core_clk;

	function automatic logic [31:0] en_of(input logic [31:0] r);
		return {22'h0, r[30], r[28], r[7:0]};
	endfunction

	task automatic complete_run();
		if (miscompares == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			$display("Error %s expected %h seen %h", name, exp, seen);
			miscompares++;
		end
	endtask

	// One bus access, held until waitrequest is sampled low
	task automatic acc(input logic rd, input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] be, output logic [31:0] r);
		int n;
		n = 0;
		@(posedge core_clk);
		req.read <= rd;
		req.write <= !rd;
		req.address <= a;
		req.writedata <= d;
		req.byteenable <= be;
		do
		begin
			@(posedge core_clk);
			n++;
		end while (waitreq !== 1'b0 && n < 50);
		r = rdata;
		req.read <= 1'b0;
		req.write <= 1'b0;
		if (waitreq !== 1'b0)
		begin
			$display("Error bus_wait expected 0 seen %b", waitreq);
			miscompares++;
			complete_run();
		end
	endtask

	initial
	begin
		core_clk = 1'b0;
		rstn = 1'b0;
		req = '0;
		sleep_now = 1'b0;
		deep_sleep_now = 1'b0;
		unit_sel = '0;
		miscompares = 0;
		n_compared = 0;
		repeat (6) @(posedge core_clk);
		rstn <= 1'b1;
		#1;
		chk("unit_clk_en", {22'h0, clk_en}, 32'h0);
		for (int i = 0; i < 3; i++)
		begin
			acc(1'b1, gofs[i], 32'h0, 4'hf, q);
			chk("gate_reset", q, 32'h0);
			acc(1'b0, gofs[i], 32'hffff_ffff, 4'hf, q);
			acc(1'b1, gofs[i], 32'h0, 4'hf, q);
			chk("gate_bits", q, 32'h5000_00ff);
			acc(1'b0, gofs[i], gpat[i], 4'hf, q);
		end
		acc(1'b0, 12'h10c, 32'hffff_ffff, 4'hf, q);
		acc(1'b1, 12'h10c, 32'h0, 4'hf, q);
		chk("unmapped", q, 32'h0);
		for (int i = 0; i < 5; i++)
		begin
			acc(1'b0, 12'h100, {31'h0, mtab[i][0]}, 4'hf, q);
			sleep_now <= mtab[i][1];
			deep_sleep_now <= mtab[i][2];
			repeat (3) @(posedge core_clk);
			#1;
			chk("unit_clk_en", {22'h0, clk_en}, en_of(gpat[midx[i]]));
			acc(1'b1, 12'h100, 32'h0, 4'hf, q);
			chk("run_clock_config", q, {29'h0, mtab[i]});
		end
		@(posedge core_clk);
		unit_sel <= 10'h3ff;
		@(posedge core_clk);
		unit_sel <= '0;
		#1;
		chk("unit_fault", {22'h0, fault}, 32'h07b);
		@(posedge core_clk);
		#1;
		chk("unit_fault", {22'h0, fault}, 32'h0);
		acc(1'b0, 12'h128, 32'h0, 4'h1, q);
		acc(1'b1, 12'h128, 32'h0, 4'hf, q);
		chk("byte_lane", q, 32'h5000_0000);
		acc(1'b1, 12'h104, 32'h0, 4'hf, q);
		acc(1'b0, 12'h104, q | 32'h0000_0040, 4'hf, q);
		acc(1'b1, 12'h104, 32'h0, 4'hf, q);
		chk("read_modify_write", q, 32'h1000_0041);
		@(posedge core_clk);
		rstn <= 1'b0;
		@(posedge core_clk);
		rstn <= 1'b1;
		acc(1'b1, 12'h128, 32'h0, 4'hf, q);
		chk("gate_after_reset", q, 32'h0);
		#1;
		chk("unit_clk_en", {22'h0, clk_en}, 32'h0);
		complete_run();
	end
endmodule
